// *** design/dps_pkg.sv ***
// constants, types and register layout for the serial-port host controller
`default_nettype none
package dps_pkg;
	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int STROBE_SETUP_NS = 8; // strobe high before first shift-clock rise
	localparam int DATA_SETUP_NS = 3;
	localparam int STROBE_LOW_NS = 20; // least strobe low time between frames
	localparam int STROBE_HIGH_NS = 10; // least strobe high time in shared-bus mode
	localparam int LAST_RISE_TO_STROBE_NS = 10;
	localparam int SHIFT_PERIOD_MIN_NS = 20; // 50 MHz ceiling of the port
	localparam int READ_DELAY_PS = 8200; // shift-clock rise to data out, no load
	localparam int SYNC_CYCLES = 3; // pin synchroniser latency
	// least times round up to whole cycles, never below one
	localparam int STROBE_SETUP_CYC = (STROBE_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int LAST_RISE_CYC = (LAST_RISE_TO_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int SHIFT_HALF_MIN_CYC = (SHIFT_PERIOD_MIN_NS * CLK_MHZ + 1999) / 2000;
	localparam int READ_DELAY_CYC = (READ_DELAY_PS * CLK_MHZ + 999999) / 1000000;
	localparam int READ_PATH_CYC = READ_DELAY_CYC + SYNC_CYCLES + 1;
	// --------------------------------------------------------------
	// frame layout
	// --------------------------------------------------------------
	localparam int FRAME_BITS = 32;
	localparam int PAYLOAD_W = 24;
	localparam int LEGACY_ADDR_W = 6;
	localparam int SHARED_ADDR_W = 5;
	localparam int TARGET_W = 3;
	localparam logic [2:0] TARGET_RST = 3'h0; // synthesizer chip address
	// --------------------------------------------------------------
	// software register map (word index)
	// --------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PAYLOAD = 3'h1;
	localparam logic [2:0] REG_ADDR = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_RXDATA = 3'h4;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MODE_BIT = 1; // 0 legacy, 1 shared-bus
	localparam int CTRL_READ_BIT = 2; // legacy read instead of write
	localparam int CTRL_CLEAR_BIT = 3; // clears done and refused
	localparam int ADDR_TARGET_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_MODE_LSB = 4;
	localparam int STAT_LOCK_BIT = 6;
	localparam int STAT_LOCK_VALID_BIT = 7;
	localparam logic [23:0] PAYLOAD_RST = 24'h000000;
	localparam logic [5:0] ADDR_RST = 6'h00;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {MODE_NONE, MODE_LEGACY, MODE_SHARED} port_mode_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	typedef struct packed {
		logic port_select_strobe;
		logic shift_clock;
		logic serial_in;
	} link_pins_t;
endpackage
`default_nettype wire

// *** design/pin_sync.sv ***
// three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level
);
	logic meta_reg;
	logic s2_reg;
	logic s3_reg;

	// --------------------------------------------------------------
	// capture chain
	// --------------------------------------------------------------
	// the first stage feeds only the second; nothing else looks at it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
		end
	end

	// filtered level follows only when the last two stages match
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end
endmodule
`default_nettype wire

// *** design/dps_host.sv ***
// host controller that drives the dual-protocol synthesizer serial port
//
// The plain strobed port was left to the implementer.
`default_nettype none
module dps_host #(
	parameter int HALF_CYCLES = 6 // clk cycles per shift-clock half period
) (
	input wire logic clk,
	input wire logic reset,
	input wire dps_pkg::bus_req_t bus_req,
	output logic [31:0] rdata,
	output dps_pkg::link_pins_t pins,
	input wire logic lock_or_serial_out,
	output logic lock_indicator,
	output logic lock_valid,
	output logic busy
);
	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	// a half period must cover every setup time and the readback path
	if (HALF_CYCLES < dps_pkg::READ_PATH_CYC || HALF_CYCLES < dps_pkg::SHIFT_HALF_MIN_CYC ||
		HALF_CYCLES < dps_pkg::STROBE_SETUP_CYC || HALF_CYCLES < dps_pkg::STROBE_LOW_CYC ||
		HALF_CYCLES < dps_pkg::STROBE_HIGH_CYC || HALF_CYCLES < dps_pkg::LAST_RISE_CYC ||
		HALF_CYCLES < dps_pkg::DATA_SETUP_CYC || HALF_CYCLES > 255) begin : g_bad_half
		$error("HALF_CYCLES cannot meet the port timing");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_TAIL, ST_STROBE, ST_GAP} state_t;

	state_t state_reg;
	dps_pkg::port_mode_t mode_reg;
	dps_pkg::port_mode_t frame_mode_reg;
	logic [7:0] div_reg;
	logic tick;
	logic [5:0] rise_reg;
	logic [31:0] tx_reg;
	logic [31:0] cap_reg;
	logic [31:0] rx_reg;
	logic [23:0] payload_reg;
	logic [5:0] addr_reg;
	logic [2:0] target_reg;
	logic mode_sel_reg;
	logic done_reg;
	logic refused_reg;
	logic strobe_reg;
	logic shift_clock_reg;
	logic serial_in_reg;
	logic pin_level;
	logic start_req;
	logic start_ok;
	logic want_shared;
	logic want_read;
	logic clear_req;
	logic [31:0] frame_word;
	logic [31:0] status_word;

	// --------------------------------------------------------------
	// readback pin
	// --------------------------------------------------------------
	pin_sync u_pin_sync (
		.clk(clk),
		.reset(reset),
		.pin(lock_or_serial_out),
		.level(pin_level)
	);

	// --------------------------------------------------------------
	// request decode
	// --------------------------------------------------------------
	// a start while busy, or in a protocol other than the committed one, is refused
	assign start_req = bus_req.wr && bus_req.addr == dps_pkg::REG_CTRL &&
		bus_req.wdata[dps_pkg::CTRL_START_BIT];
	assign want_shared = bus_req.wdata[dps_pkg::CTRL_MODE_BIT];
	assign want_read = bus_req.wdata[dps_pkg::CTRL_READ_BIT] && !want_shared;
	assign clear_req = bus_req.wr && bus_req.addr == dps_pkg::REG_CTRL &&
		bus_req.wdata[dps_pkg::CTRL_CLEAR_BIT];
	assign start_ok = start_req && state_reg == ST_IDLE && (mode_reg == dps_pkg::MODE_NONE ||
		(mode_reg == dps_pkg::MODE_SHARED) == want_shared);

	// legacy frame: flag, address, data, one trailing clock; shared: data, address, chip
	always_comb begin
		if (want_shared) begin
			frame_word = {payload_reg, addr_reg[dps_pkg::SHARED_ADDR_W-1:0], target_reg};
		end else begin
			frame_word = {want_read, addr_reg, payload_reg, 1'b0};
		end
	end

	// --------------------------------------------------------------
	// software registers
	// --------------------------------------------------------------
	// payload and address are staged here and copied into the frame at start
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			payload_reg <= dps_pkg::PAYLOAD_RST;
			addr_reg <= dps_pkg::ADDR_RST;
			target_reg <= dps_pkg::TARGET_RST;
		end else if (bus_req.wr && bus_req.addr == dps_pkg::REG_PAYLOAD) begin
			payload_reg <= bus_req.wdata[dps_pkg::PAYLOAD_W-1:0];
		end else if (bus_req.wr && bus_req.addr == dps_pkg::REG_ADDR) begin
			addr_reg <= bus_req.wdata[dps_pkg::LEGACY_ADDR_W-1:0];
			target_reg <= bus_req.wdata[dps_pkg::ADDR_TARGET_LSB +: dps_pkg::TARGET_W];
		end
	end

	// last requested protocol, shown back in the control word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_sel_reg <= 1'b0;
		end else if (start_req) begin
			mode_sel_reg <= want_shared;
		end
	end

	// sticky flags: a setting event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			if (state_reg == ST_GAP && tick) begin
				done_reg <= 1'b1;
			end else if (clear_req || start_ok) begin
				done_reg <= 1'b0;
			end
			if (start_req && !start_ok) begin
				refused_reg <= 1'b1;
			end else if (clear_req) begin
				refused_reg <= 1'b0;
			end
		end
	end

	// the device commits on its first activity and never changes until power-down
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg <= dps_pkg::MODE_NONE;
		end else if (start_ok && mode_reg == dps_pkg::MODE_NONE) begin
			// strobe first picks legacy, clock first picks shared-bus
			mode_reg <= want_shared ? dps_pkg::MODE_SHARED : dps_pkg::MODE_LEGACY;
		end
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[dps_pkg::STAT_BUSY_BIT] = busy;
		status_word[dps_pkg::STAT_DONE_BIT] = done_reg;
		status_word[dps_pkg::STAT_REFUSED_BIT] = refused_reg;
		status_word[dps_pkg::STAT_MODE_LSB +: 2] = mode_reg;
		status_word[dps_pkg::STAT_LOCK_BIT] = lock_indicator;
		status_word[dps_pkg::STAT_LOCK_VALID_BIT] = lock_valid;
	end

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 32'h00000000;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				dps_pkg::REG_CTRL: rdata <= {30'h0, mode_sel_reg, 1'b0};
				dps_pkg::REG_PAYLOAD: rdata <= {8'h00, payload_reg};
				dps_pkg::REG_ADDR: rdata <= {21'h0, target_reg, 2'h0, addr_reg};
				dps_pkg::REG_STATUS: rdata <= status_word;
				dps_pkg::REG_RXDATA: rdata <= rx_reg;
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// --------------------------------------------------------------
	// shift-clock divider
	// --------------------------------------------------------------
	// restarts at each start so the first half period is a full one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_reg <= 8'h00;
		end else if (state_reg == ST_IDLE || tick) begin
			div_reg <= 8'(HALF_CYCLES - 1);
		end else begin
			div_reg <= div_reg - 8'h01;
		end
	end
	assign tick = state_reg != ST_IDLE && div_reg == 8'h00;

	// --------------------------------------------------------------
	// frame sequencer
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			frame_mode_reg <= dps_pkg::MODE_NONE;
			rise_reg <= 6'h00;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_ok) begin
						state_reg <= ST_LEAD;
						frame_mode_reg <= want_shared ? dps_pkg::MODE_SHARED
							: dps_pkg::MODE_LEGACY;
						rise_reg <= 6'h00;
					end
				end
				ST_LEAD: begin
					if (tick) begin
						state_reg <= ST_HIGH;
						rise_reg <= 6'h01;
					end
				end
				ST_HIGH: begin
					if (tick) begin
						if (rise_reg != 6'(dps_pkg::FRAME_BITS)) begin
							state_reg <= ST_LOW;
						end else if (frame_mode_reg == dps_pkg::MODE_SHARED) begin
							state_reg <= ST_TAIL;
						end else begin
							state_reg <= ST_GAP;
						end
					end
				end
				ST_LOW: begin
					if (tick) begin
						state_reg <= ST_HIGH;
						rise_reg <= rise_reg + 6'h01;
					end
				end
				ST_TAIL: begin
					if (tick) begin
						state_reg <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (tick) begin
						state_reg <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (tick) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end
	assign busy = state_reg != ST_IDLE;

	// --------------------------------------------------------------
	// link pins
	// --------------------------------------------------------------
	// all pins idle low from reset so the device sees no edge early
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strobe_reg <= 1'b0;
		end else if (start_ok && !want_shared) begin
			strobe_reg <= 1'b1;
		end else if (state_reg == ST_HIGH && tick && frame_mode_reg == dps_pkg::MODE_LEGACY &&
			rise_reg == 6'(dps_pkg::FRAME_BITS)) begin
			strobe_reg <= 1'b0; // dropped with falling edge 32
		end else if (state_reg == ST_TAIL && tick) begin
			strobe_reg <= 1'b1; // a half period after fall 32 latches the word
		end else if (state_reg == ST_STROBE && tick) begin
			strobe_reg <= 1'b0;
		end
	end

	// rising edges in LEAD and LOW, falling edges out of HIGH
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_clock_reg <= 1'b0;
		end else if ((state_reg == ST_LEAD || state_reg == ST_LOW) && tick) begin
			shift_clock_reg <= 1'b1;
		end else if (state_reg == ST_HIGH && tick) begin
			shift_clock_reg <= 1'b0;
		end
	end

	// next bit goes out with each falling edge, MSB first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_reg <= 32'h00000000;
			serial_in_reg <= 1'b0;
		end else if (start_ok) begin
			tx_reg <= {frame_word[30:0], 1'b0};
			serial_in_reg <= frame_word[31]; // first frame bit (legacy flag, shared data MSB) valid before the first rise
		end else if (state_reg == ST_HIGH && tick) begin
			tx_reg <= {tx_reg[30:0], 1'b0};
			serial_in_reg <= rise_reg == 6'(dps_pkg::FRAME_BITS) ? 1'b0 : tx_reg[31];
		end
	end
	assign pins = '{port_select_strobe: strobe_reg, shift_clock: shift_clock_reg,
		serial_in: serial_in_reg};

	// --------------------------------------------------------------
	// readback capture
	// --------------------------------------------------------------
	// sampled at the end of each high phase, i.e. at the falling edge, which leaves
	// the device delay plus the synchroniser inside one half period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_reg <= 32'h00000000;
		end else if (start_ok) begin
			cap_reg <= 32'h00000000;
		end else if (state_reg == ST_HIGH && tick) begin
			cap_reg <= {cap_reg[30:0], pin_level};
		end
	end

	// legacy reads keep the bits of falls 8..31; shared frames keep all 32 samples
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_reg <= 32'h00000000;
		end else if (state_reg == ST_GAP && tick) begin
			if (frame_mode_reg == dps_pkg::MODE_LEGACY) begin
				rx_reg <= {8'h00, cap_reg[24:1]};
			end else begin
				rx_reg <= cap_reg; // register picked by the last read address
			end
		end
	end

	// --------------------------------------------------------------
	// lock indication
	// --------------------------------------------------------------
	// the shared pin only means lock while the strobe is low and no frame runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lock_indicator <= 1'b0;
			lock_valid <= 1'b0;
		end else begin
			lock_valid <= state_reg == ST_IDLE && !strobe_reg &&
				mode_reg != dps_pkg::MODE_NONE;
			if (state_reg == ST_IDLE && !strobe_reg) begin
				lock_indicator <= pin_level;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/dps_host_props.sv ***
// concurrent checks on the pins and handshake of the serial-port host controller
`default_nettype none
module dps_host_props #(
	parameter int HALF_CYCLES = 6
) (
	input wire logic clk,
	input wire logic reset,
	input wire dps_pkg::bus_req_t bus_req,
	input wire logic [31:0] rdata,
	input wire dps_pkg::link_pins_t pins,
	input wire logic lock_or_serial_out,
	input wire logic lock_indicator,
	input wire logic lock_valid,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// --------------------------------------------------------------
	// helper logic
	// --------------------------------------------------------------
	logic sclk_q_reg;
	logic [5:0] rise_cnt_reg;
	// delayed copy of the shift clock for edge counting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_q_reg <= 1'b0;
		end else begin
			sclk_q_reg <= pins.shift_clock;
		end
	end
	// rises of the running frame; lags one cycle, which every check allows for
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rise_cnt_reg <= 6'h00;
		end else if (!busy) begin
			rise_cnt_reg <= 6'h00;
		end else if (pins.shift_clock && !sclk_q_reg) begin
			rise_cnt_reg <= rise_cnt_reg + 6'h01;
		end
	end
	sequence clock_quiet_s;
		!pins.shift_clock [*2];
	endsequence
	sequence strobe_pulse_s;
		pins.port_select_strobe [*2] ##[1:600] !pins.port_select_strobe;
	endsequence
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	idle_pins_a: assert property (!busy |-> pins == '0)
		else $error("link pins active while idle");
	legacy_setup_a: assert property ($rose(pins.port_select_strobe) && rise_cnt_reg == 6'h00 |-> clock_quiet_s)
		else $error("shift clock too soon after strobe");
	data_setup_a: assert property ($rose(pins.shift_clock) |-> $stable(pins.serial_in))
		else $error("serial input moved at a rising edge");
	data_change_a: assert property (busy && $changed(pins.serial_in) |-> !pins.shift_clock)
		else $error("serial input moved while clock high");
	clock_high_a: assert property ($rose(pins.shift_clock) |-> pins.shift_clock [*2])
		else $error("shift clock high phase too short");
	frame_length_a: assert property ($fell(busy) |-> rise_cnt_reg == 6'd32)
		else $error("frame did not carry 32 clock rises");
	legacy_end_a: assert property ($fell(pins.shift_clock) && rise_cnt_reg == 6'd32 &&
		$past(pins.port_select_strobe) |-> $fell(pins.port_select_strobe))
		else $error("strobe not dropped on falling edge 32");
	strobe_rise_a: assert property ($rose(pins.port_select_strobe) |-> rise_cnt_reg == 6'h00 ||
		(rise_cnt_reg == 6'd32 && !$past(pins.shift_clock, 2)))
		else $error("strobe rose in mid frame");
	shared_pulse_a: assert property ($rose(pins.port_select_strobe) && rise_cnt_reg == 6'd32
		|-> strobe_pulse_s)
		else $error("shared-bus strobe pulse malformed");
	lock_valid_a: assert property (lock_valid |-> $past(!pins.port_select_strobe))
		else $error("lock reported valid with strobe high");
endmodule
bind dps_host dps_host_props #(.HALF_CYCLES(HALF_CYCLES)) props_i (.clk(clk), .reset(reset),
	.bus_req(bus_req), .rdata(rdata), .pins(pins), .lock_or_serial_out(lock_or_serial_out),
	.lock_indicator(lock_indicator), .lock_valid(lock_valid), .busy(busy));
`default_nettype wire

// *** test/dps_device_model.sv ***
// behavioural model of the synthesizer serial port in both protocols
`default_nettype none
module dps_device_model #(
	parameter logic [23:0] DEVICE_ID = 24'h3c5a01 // arbitrary value
) (
	input wire logic power_down,
	input wire dps_pkg::link_pins_t pins,
	input wire logic lock_in,
	output logic lock_or_serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mode; // 0 none, 1 legacy, 2 shared-bus
	logic [31:0] shreg;
	logic [31:0] word;
	logic [23:0] regs [64];
	logic [4:0] rd_addr;
	logic rd_flag, driving, sdo, sclk_q, sen_q;
	int rises;
	// register defaults; the identifier is not stored, so reset cannot touch it
	task automatic clear_regs();
		foreach (regs[i]) regs[i] = 24'h000000;
		rd_addr = 5'h00;
	endtask
	task automatic store(input logic [5:0] adr, input logic [23:0] val);
		if (adr != 6'h00) begin
			regs[adr] = val;
		end else begin
			if (mode == 2'd2) rd_addr = val[4:0];
			if (val[5]) clear_regs();
		end
	endtask
	function automatic logic [23:0] fetch(input logic [5:0] adr);
		return (adr == 6'h00) ? DEVICE_ID : regs[adr];
	endfunction
	// every pin edge is handled here so protocol state has a single writer
	always @(pins.shift_clock, pins.port_select_strobe, power_down) begin
		if (power_down) begin
			mode = 2'd0;
			rises = 0;
			{driving, sdo, rd_flag, sclk_q, sen_q} = 5'h00;
			shreg = 32'h0;
			word = 32'h0;
			clear_regs();
		end else begin
			if (pins.port_select_strobe && !sen_q) begin
				if (mode == 2'd0) mode = 2'd1;
				if (mode == 2'd2 && rises == 32 && shreg[2:0] == dps_pkg::TARGET_RST)
					store({1'b0, shreg[7:3]}, shreg[31:8]);
				rises = 0;
				driving = 1'b0;
			end
			// a legacy write lands only once the whole frame has been clocked in
			if (!pins.port_select_strobe && sen_q && mode == 2'd1 && !rd_flag && rises == 32)
				store(shreg[30:25], shreg[24:1]);
			if (pins.shift_clock && !sclk_q) begin
				if (mode == 2'd0) mode = 2'd2;
				rises++;
				shreg = {shreg[30:0], pins.serial_in};
				if (mode == 2'd1) begin
					if (rises == 1) rd_flag = pins.serial_in;
					if (rd_flag && rises == 7) word = {8'h00, fetch(shreg[5:0])};
					driving = rd_flag && rises >= 8 && rises <= 31;
					if (driving) sdo = word[31 - rises];
				end else begin
					if (rises == 1) word = {fetch({1'b0, rd_addr}), 8'h00};
					driving = rises <= 32;
					// the chip address is only known at rise 32; a foreign one releases the pin
					if (rises == 32 && shreg[2:0] != dps_pkg::TARGET_RST) driving = 1'b0;
					if (driving) sdo = word[32 - rises];
				end
			end
			sclk_q = pins.shift_clock;
			sen_q = pins.port_select_strobe;
		end
	end
	assign lock_or_serial_out = driving ? sdo : lock_in;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the serial-port host controller against the device model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] DEV_ID = 24'h3c5a01; // arbitrary value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic lock_in = 1'b0;
	dps_pkg::bus_req_t bus_req = '0;
	dps_pkg::link_pins_t pins;
	logic [31:0] rdata, rd_val;
	logic lock_line, lock_indicator, lock_valid, busy;
	logic [5:0] a;
	logic [23:0] d;
	int err_count = 0;
	int comparisons = 0;
	int seed = 32'h6b3c3b55;
	always #4 clk = ~clk;
	dps_host #(.HALF_CYCLES(6)) uut (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
		.pins(pins), .lock_or_serial_out(lock_line), .lock_indicator(lock_indicator),
		.lock_valid(lock_valid), .busy(busy));
	dps_device_model #(.DEVICE_ID(DEV_ID)) dev (.power_down(reset), .pins(pins),
		.lock_in(lock_in), .lock_or_serial_out(lock_line));
	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task bus_wr(input logic [2:0] adr, input logic [31:0] wd);
		@(posedge clk) bus_req <= '{addr: adr, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus_req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task bus_rd(input logic [2:0] adr, output logic [31:0] v);
		@(posedge clk) bus_req <= '{addr: adr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus_req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	function automatic logic [31:0] ctrl_word(input logic shared, input logic rdf);
		return 32'h1 | (32'(shared) << dps_pkg::CTRL_MODE_BIT) | (32'(rdf) << dps_pkg::CTRL_READ_BIT);
	endfunction
	// one whole frame: payload, address, start, then wait for the end under a bound
	task frame(input logic shared, input logic rdf, input logic [5:0] adr, input logic [2:0] chip,
		input logic [23:0] pay);
		int n;
		bus_wr(dps_pkg::REG_PAYLOAD, {8'h00, pay});
		bus_wr(dps_pkg::REG_ADDR, {21'h0, chip, 2'h0, adr});
		bus_wr(dps_pkg::REG_CTRL, ctrl_word(shared, rdf));
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (busy !== 1'b0 && n < 1000);
		if (n >= 1000) begin
			err_count++;
			stop_test();
		end
	endtask
	task rx(input string name, input logic [31:0] exp);
		bus_rd(dps_pkg::REG_RXDATA, rd_val);
		check(name, rd_val, exp);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		// register defaults, an unmapped index among them
		for (int i = 0; i < 6; i++) begin
			bus_rd(3'(i), rd_val);
			check("reset value", rd_val, 32'h0);
		end
		a = 6'h3f;
		d = 24'h800001;
		frame(1'b0, 1'b0, a, 3'h0, d);
		check("model mode", {30'h0, dev.mode}, 32'h1);
		bus_rd(dps_pkg::REG_STATUS, rd_val);
		check("status legacy", rd_val & 32'h37, 32'h12);
		// legacy write then read back, first at the top address with edge bits
		for (int k = 0; k < 5; k++) begin
			frame(1'b0, 1'b0, a, 3'h0, d);
			frame(1'b0, 1'b1, a, 3'h0, 24'h0);
			rx("legacy read", {8'h00, d});
			a = 6'($random(seed));
			if (a == 6'h00) a = 6'h2a;
			d = 24'($random(seed));
		end
		frame(1'b0, 1'b1, 6'h00, 3'h0, 24'h0);
		rx("identifier", {8'h00, DEV_ID});
		// a shared-bus start after legacy was committed is refused
		frame(1'b1, 1'b0, a, 3'h0, d);
		bus_rd(dps_pkg::REG_STATUS, rd_val);
		check("status refused", rd_val & 32'h35, 32'h14);
		check("mode kept", {30'h0, dev.mode}, 32'h1);
		// the clear bit drops both sticky flags but keeps the committed protocol
		bus_wr(dps_pkg::REG_CTRL, 32'h1 << dps_pkg::CTRL_CLEAR_BIT);
		bus_rd(dps_pkg::REG_STATUS, rd_val);
		check("status cleared", rd_val & 32'h37, 32'h10);
		@(posedge clk) lock_in <= 1'b1;
		repeat (10) @(posedge clk);
		#1 check("lock level", {30'h0, lock_indicator, lock_valid}, 32'h3);
		// soft reset through register zero clears an earlier write
		frame(1'b0, 1'b0, 6'h05, 3'h0, 24'h00abcd);
		frame(1'b0, 1'b0, 6'h00, 3'h0, 24'h000020);
		frame(1'b0, 1'b1, 6'h05, 3'h0, 24'h0);
		rx("after soft reset", 32'h0);
		// power cycle, then commit to the shared bus
		@(posedge clk) reset <= 1'b1;
		lock_in <= 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		a = 6'($random(seed)) & 6'h1f;
		if (a == 6'h00) a = 6'h13;
		d = 24'($random(seed));
		frame(1'b1, 1'b0, a, 3'h0, d);
		check("model mode", {30'h0, dev.mode}, 32'h2);
		frame(1'b1, 1'b0, 6'h00, 3'h0, {19'h0, a[4:0]});
		rx("shared identifier", {DEV_ID, 8'h00});
		frame(1'b1, 1'b0, 6'h00, 3'h0, {19'h0, a[4:0]});
		rx("shared readback", {d, 8'h00});
		// a frame for another chip address must leave the register alone
		frame(1'b1, 1'b0, a, 3'h5, ~d);
		frame(1'b1, 1'b0, 6'h00, 3'h0, {19'h0, a[4:0]});
		rx("foreign chip", {d, 8'h00});
		stop_test();
	end
	// about 21 frames of some 400 cycles each are expected; the span leaves ample margin
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		stop_test();
	end
endmodule
`default_nettype wire
